/* logic/scrb_bank.sv */
/*
 * serial-port register bank with staged and active copies.
 * assumes: all pins synchronous to ref_clk, sclk far slower than
 * ref_clk, one register per chip-select frame.
 */
`timescale 1ns/100ps
`default_nettype none
`include "scrb_map.svh"

// What this block does
// [R1] decode addresses zero through 0x16
// [R2] slots 0x05 and 0x06 are unimplemented
// [R3] transfer length set per addressed register
// [R4] bit zero is least significant everywhere
// [R5] control and profile writes staged until update or profile change
// [R6] first control register is four bytes
// [R7] bit 31 enables waveform memory
// [R8] bits 30:29 select playback destination
// [R9] bit 23 gates keying pin in manual mode
// [R10] profile seven low byte flags and mode
// [R11] profile seven step, end, start fields
// [R12] staging copied to active in one cycle
module scrb_bank
	import scrb_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// serial port
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        sdio_in,
	output var  logic        sdio_out,
	output var  logic        sdio_oe,
	// update sources
	input  wire logic        io_update,
	input  wire logic [2:0]  profile_sel,
	// keying pin
	input  wire logic        amplitude_keying,
	output var  logic        amplitude_keying_gated,
	// active control fields
	output var  logic        wave_mem_enable,
	output var  logic [1:0]  playback_dest,
	output var  logic        keying_pin_enable,
	// active profile seven fields
	output var  logic [15:0] prof7_step_rate,
	output var  logic [9:0]  prof7_end_addr,
	output var  logic [9:0]  prof7_start_addr,
	output var  logic        prof7_no_dwell_high,
	output var  logic        prof7_zero_crossing,
	output var  logic [2:0]  prof7_mode,
	// memory word
	output var  logic [31:0] mem_word,
	output var  logic        mem_word_valid
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic addr_ok(input scrb_addr_t a);
		addr_ok = (a <= `SCRB_ADDR_LAST) && (a != `SCRB_ADDR_HOLE_A) && (a != `SCRB_ADDR_HOLE_B);
	endfunction

	function automatic scrb_nbytes_t byte_count(input scrb_addr_t a);
		if (a == `SCRB_ADDR_CTRL_FIRST) begin
			byte_count = `SCRB_BYTES_CTRL_FIRST;
		end else if (a >= `SCRB_ADDR_PROF_FIRST && a <= `SCRB_ADDR_PROF_SEVEN) begin
			byte_count = `SCRB_BYTES_PROFILE;
		end else if (a == `SCRB_ADDR_MEM_WORD) begin
			byte_count = `SCRB_BYTES_MEM_WORD;
		end else begin
			byte_count = `SCRB_BYTES_DEFAULT;
		end
	endfunction

	function automatic logic [5:0] last_bit(input scrb_nbytes_t n);
		logic [3:0] m;
		m = n - 4'h1;
		last_bit = {m[2:0], 3'b111};
	endfunction

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	scrb_state_t  state;
	logic         sclk_prev;
	logic [5:0]   bit_cnt;
	scrb_word_t   in_sh;
	scrb_word_t   out_sh;
	scrb_addr_t   addr;
	logic         rd;
	scrb_nbytes_t nbytes;
	logic         wr_pulse;
	scrb_addr_t   wr_addr;
	scrb_word_t   wr_data;
	logic [31:0]  stg_ctrl;
	scrb_word_t   stg_prof7;
	logic [31:0]  active_ctrl;
	scrb_word_t   active_prof7;
	logic         upd_prev;
	logic [2:0]   prof_prev;
	logic         sclk_rise;
	logic         sclk_fall;
	logic         update_evt;
	scrb_addr_t   next_addr;
	scrb_word_t   next_in;
	scrb_nbytes_t next_nbytes;
	scrb_word_t   rd_val;
	assign sclk_rise   = sclk & ~sclk_prev;
	assign sclk_fall   = ~sclk & sclk_prev;
	assign next_in     = {in_sh[62:0], sdio_in};
	assign next_addr   = next_in[4:0];
	assign next_nbytes = byte_count(next_addr);                        // [R3]
	assign update_evt  = (io_update & ~upd_prev) | (profile_sel != prof_prev); // [R5]

	// read value of staged registers and the memory word, left aligned to the frame length
	always_comb begin
		rd_val = 64'h0000_0000_0000_0000;
		unique case (next_addr)
			`SCRB_ADDR_CTRL_FIRST: rd_val = {stg_ctrl, 32'h0000_0000};     // [R6]
			`SCRB_ADDR_PROF_SEVEN: rd_val = stg_prof7;
			`SCRB_ADDR_MEM_WORD:   rd_val = wave_mem_enable ?
				{mem_word, 32'h0000_0000} : 64'h0000_0000_0000_0000;       // [R7]
			default:               rd_val = 64'h0000_0000_0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// edge history
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sclk_prev <= 1'b0;
			upd_prev  <= 1'b0;
			prof_prev <= 3'h0;
		end else begin
			sclk_prev <= sclk;
			upd_prev  <= io_update;
			prof_prev <= profile_sel;
		end
	end

	// ---------------------------------------------------------------
	// serial frame
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state    <= SCRB_IDLE;
			bit_cnt  <= 6'h00;
			in_sh    <= 64'h0000_0000_0000_0000;
			addr     <= 5'h00;
			rd       <= 1'b0;
			nbytes   <= 4'h0;
			wr_pulse <= 1'b0;
			wr_addr  <= 5'h00;
			wr_data  <= 64'h0000_0000_0000_0000;
		end else begin
			wr_pulse <= 1'b0;
			if (cs_n) begin
				state <= SCRB_IDLE;
			end else begin
				unique case (state)
					SCRB_IDLE: begin
						state   <= SCRB_INSTR;
						bit_cnt <= 6'h00;
					end
					SCRB_INSTR: begin
						if (sclk_rise) begin
							in_sh   <= next_in;
							bit_cnt <= bit_cnt + 6'h01;
							if (bit_cnt == `SCRB_INSTR_LAST_BIT) begin
								addr    <= next_addr;
								rd      <= next_in[`SCRB_INSTR_READ_BIT];
								nbytes  <= next_nbytes;
								bit_cnt <= 6'h00;
								state   <= addr_ok(next_addr) ? SCRB_DATA : SCRB_SKIP; // [R1] [R2]
							end
						end
					end
					SCRB_DATA: begin
						if (sclk_rise) begin
							in_sh   <= next_in;
							bit_cnt <= bit_cnt + 6'h01;
							if (bit_cnt == last_bit(nbytes)) begin         // [R3]
								wr_pulse <= ~rd;
								wr_addr  <= addr;
								wr_data  <= next_in;
								state    <= SCRB_SKIP;
							end
						end
					end
					SCRB_SKIP: state <= SCRB_SKIP;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// read shifter
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			out_sh   <= 64'h0000_0000_0000_0000;
			sdio_out <= 1'b0;
			sdio_oe  <= 1'b0;
		end else if (cs_n) begin
			sdio_oe  <= 1'b0;
		end else if (state == SCRB_INSTR && sclk_rise && bit_cnt == `SCRB_INSTR_LAST_BIT) begin
			out_sh   <= {rd_val[62:0], 1'b0};
			sdio_out <= rd_val[63];
			sdio_oe  <= next_in[`SCRB_INSTR_READ_BIT] & addr_ok(next_addr);
		end else if (state == SCRB_DATA && rd && sclk_fall) begin
			out_sh   <= {out_sh[62:0], 1'b0};
			sdio_out <= out_sh[63];
		end else if (state != SCRB_DATA) begin
			sdio_oe  <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// staging copies
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stg_ctrl  <= `SCRB_CF_RESET;
			stg_prof7 <= `SCRB_PR_RESET;
		end else if (wr_pulse) begin
			if (wr_addr == `SCRB_ADDR_CTRL_FIRST) begin
				stg_ctrl <= wr_data[31:0] & `SCRB_CF_MASK;                  // [R4] [R6]
			end
			if (wr_addr == `SCRB_ADDR_PROF_SEVEN) begin
				stg_prof7 <= wr_data & `SCRB_PR_MASK;                       // [R10] [R11]
			end
		end
	end

	// memory word, written straight through while memory is enabled
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mem_word       <= `SCRB_MEM_RESET;
			mem_word_valid <= 1'b0;
		end else begin
			mem_word_valid <= 1'b0;
			if (wr_pulse && wr_addr == `SCRB_ADDR_MEM_WORD && wave_mem_enable) begin // [R7]
				mem_word       <= wr_data[31:0];
				mem_word_valid <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// active copies
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			active_ctrl       <= `SCRB_CF_RESET;
			active_prof7      <= `SCRB_PR_RESET;
			keying_pin_enable <= 1'b0;
		end else if (update_evt) begin                                 // [R5]
			active_ctrl       <= stg_ctrl;                              // [R12]
			active_prof7      <= stg_prof7;                             // [R12]
			keying_pin_enable <= stg_ctrl[`SCRB_CF_KEY_EXT] &&
				stg_ctrl[`SCRB_CF_KEY_MODE_HI:`SCRB_CF_KEY_MODE_LO] == `SCRB_CF_KEY_MANUAL; // [R9]
		end
	end

	assign wave_mem_enable     = active_ctrl[`SCRB_CF_WM_EN];                      // [R7]
	assign playback_dest       = active_ctrl[`SCRB_CF_DEST_HI:`SCRB_CF_DEST_LO];   // [R8]
	assign prof7_step_rate     = active_prof7[`SCRB_PR_STEP_HI:`SCRB_PR_STEP_LO];  // [R11]
	assign prof7_end_addr      = active_prof7[`SCRB_PR_END_HI:`SCRB_PR_END_LO];    // [R11]
	assign prof7_start_addr    = active_prof7[`SCRB_PR_START_HI:`SCRB_PR_START_LO]; // [R11]
	assign prof7_no_dwell_high = active_prof7[`SCRB_PR_NO_DWELL];                  // [R10]
	assign prof7_zero_crossing = active_prof7[`SCRB_PR_ZERO_CROSS];                // [R10]
	assign prof7_mode          = active_prof7[`SCRB_PR_MODE_HI:`SCRB_PR_MODE_LO];  // [R10]

	// keying pin passes only when enabled
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			amplitude_keying_gated <= 1'b0;
		end else begin
			amplitude_keying_gated <= keying_pin_enable & amplitude_keying; // [R9]
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_range;
		wr_pulse |-> wr_addr <= `SCRB_ADDR_LAST;
	endproperty
	a_range: assert property (p_range) else $error("write beyond map"); // [R1]
	property p_hole;
		(!cs_n && state == SCRB_INSTR && sclk_rise && bit_cnt == `SCRB_INSTR_LAST_BIT
			&& (next_addr == `SCRB_ADDR_HOLE_A || next_addr == `SCRB_ADDR_HOLE_B))
			|=> state == SCRB_SKIP;
	endproperty
	a_hole: assert property (p_hole) else $error("hole address accepted"); // [R2]
	property p_len;
		(state == SCRB_DATA && !rd && !cs_n) |-> nbytes == byte_count(addr);
	endproperty
	a_len: assert property (p_len) else $error("frame length mismatch"); // [R3]
	property p_hold;
		!update_evt |=> $stable(active_ctrl) && $stable(active_prof7);
	endproperty
	a_hold: assert property (p_hold) else $error("active changed without update"); // [R5]
	property p_ctrl_open;
		(wr_pulse && wr_addr == `SCRB_ADDR_CTRL_FIRST) |=> stg_ctrl[28:24] == 5'h00;
	endproperty
	a_ctrl_open: assert property (p_ctrl_open) else $error("open bits stored"); // [R6]
	property p_wm_gate;
		(wr_pulse && wr_addr == `SCRB_ADDR_MEM_WORD && !wave_mem_enable) |=> !mem_word_valid;
	endproperty
	a_wm_gate: assert property (p_wm_gate) else $error("memory written while disabled"); // [R7]
	property p_dest;
		update_evt |=> playback_dest == $past(stg_ctrl[30:29]);
	endproperty
	a_dest: assert property (p_dest) else $error("destination not applied"); // [R8]
	property p_keying;
		!keying_pin_enable |=> !amplitude_keying_gated;
	endproperty
	a_keying: assert property (p_keying) else $error("keying pin leaked"); // [R9]
	property p_mode;
		update_evt |=> prof7_mode == $past(stg_prof7[2:0])
			&& prof7_zero_crossing == $past(stg_prof7[3]);
	endproperty
	a_mode: assert property (p_mode) else $error("profile mode not applied"); // [R10]
	property p_apply;
		update_evt |=> active_ctrl == $past(stg_ctrl) && active_prof7 == $past(stg_prof7);
	endproperty
	a_apply: assert property (p_apply) else $error("staged copy not applied"); // [R12]

endmodule

`default_nettype wire

/* inc/scrb_map.svh */
/*
 * address map, field positions, masks, reset values and byte counts
 * of the synthesizer control register bank.
 * assumes: included by bare name from package and design files.
 */
`ifndef SCRB_MAP_SVH
`define SCRB_MAP_SVH

// ---------------------------------------------------------------
// addresses
// ---------------------------------------------------------------
`define SCRB_ADDR_CTRL_FIRST  5'h00
`define SCRB_ADDR_HOLE_A      5'h05
`define SCRB_ADDR_HOLE_B      5'h06
`define SCRB_ADDR_PROF_FIRST  5'h0E
`define SCRB_ADDR_PROF_SEVEN  5'h15
`define SCRB_ADDR_MEM_WORD    5'h16
`define SCRB_ADDR_LAST        5'h16

// ---------------------------------------------------------------
// byte counts
// ---------------------------------------------------------------
`define SCRB_BYTES_CTRL_FIRST 4'h4
`define SCRB_BYTES_PROFILE    4'h8
`define SCRB_BYTES_MEM_WORD   4'h4
`define SCRB_BYTES_DEFAULT    4'h4

// ---------------------------------------------------------------
// instruction byte
// ---------------------------------------------------------------
`define SCRB_INSTR_READ_BIT   6
`define SCRB_INSTR_LAST_BIT   6'h07

// ---------------------------------------------------------------
// first control register fields
// ---------------------------------------------------------------
`define SCRB_CF_WM_EN         31
`define SCRB_CF_DEST_HI       30
`define SCRB_CF_DEST_LO       29
`define SCRB_CF_KEY_EXT       23
`define SCRB_CF_KEY_MODE_HI   9
`define SCRB_CF_KEY_MODE_LO   8
`define SCRB_CF_KEY_MANUAL    2'h2
`define SCRB_CF_MASK          32'hE0DF_FFFF
`define SCRB_CF_RESET         32'h0000_0000

// ---------------------------------------------------------------
// memory profile seven fields
// ---------------------------------------------------------------
`define SCRB_PR_STEP_HI       55
`define SCRB_PR_STEP_LO       40
`define SCRB_PR_END_HI        39
`define SCRB_PR_END_LO        30
`define SCRB_PR_START_HI      23
`define SCRB_PR_START_LO      14
`define SCRB_PR_NO_DWELL      5
`define SCRB_PR_ZERO_CROSS    3
`define SCRB_PR_MODE_HI       2
`define SCRB_PR_MODE_LO       0
`define SCRB_PR_MASK          64'h00FF_FFFF_C0FF_C02F
`define SCRB_PR_RESET         64'h0000_0000_0000_0000
`define SCRB_MEM_RESET        32'h0000_0000

`endif

/* inc/scrb_pkg.sv */
/*
 * types of the synthesizer control register bank.
 * assumes: scrb_map.svh on the include path.
 */
`include "scrb_map.svh"

package scrb_pkg;

	// serial frame state, one-hot
	typedef enum logic [3:0] {
		SCRB_IDLE  = 4'b0001,
		SCRB_INSTR = 4'b0010,
		SCRB_DATA  = 4'b0100,
		SCRB_SKIP  = 4'b1000
	} scrb_state_t;

	typedef logic [4:0]  scrb_addr_t;
	typedef logic [3:0]  scrb_nbytes_t;
	typedef logic [63:0] scrb_word_t;

endpackage

/* verif/scrb_host.sv */
/*
 * host controller model driving the serial port of the register bank.
 * assumes: driven and sampled on falling edges of ref_clk, each sclk
 * level held two ref_clk cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module scrb_host (
	// clock
	input  wire logic ref_clk,
	// serial port
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdio_in = 1'b0;
	end

	// ---------------------------------------------------------------
	// one frame: instruction byte then nb data bits, msb first
	// ---------------------------------------------------------------
	task automatic frame(input logic rd, input logic [4:0] adr, input int nb,
		input logic [63:0] wd, output logic [63:0] rd_o, input int cut = 999);
		logic [7:0] ins;
		int         i;
		ins = {1'b0, rd, 1'b0, adr};
		rd_o = '0;
		@(negedge ref_clk) cs_n = 1'b0;
		for (i = 0; i < 8 + nb && i < cut; i++) begin
			sdio_in = (i < 8) ? ins[7 - i] : wd[nb - 1 - (i - 8)];
			repeat (2) @(negedge ref_clk);
			sclk = 1'b1;
			repeat (2) @(negedge ref_clk);
			if (i >= 7 && i < 7 + nb)
				rd_o[nb - 1 - (i - 7)] = sdio_oe ? sdio_out : 1'b0;
			sclk = 1'b0;
		end
		@(negedge ref_clk) cs_n = 1'b1;
		// released data line shows no stale level
		sdio_in = ~sdio_in;
		repeat (4) @(negedge ref_clk);
	endtask
endmodule

`default_nettype wire

/* verif/synth_control_register_bank_tb.sv */
/*
 * self-checking bench of the register bank.
 * assumes: scrb_map.svh on the include path, scrb_host model present.
 */
`timescale 1ns/100ps
`default_nettype none
`include "scrb_map.svh"

module synth_control_register_bank_tb;
	typedef struct {logic [31:0] wv; logic [3:0] ex;} scrb_row_t;

	logic        ref_clk, rst_n, cs_n, sclk, sdio_in, sdio_out, sdio_oe;
	logic        io_update, amplitude_keying, amplitude_keying_gated;
	logic        wave_mem_enable, keying_pin_enable, mem_word_valid;
	logic        prof7_no_dwell_high, prof7_zero_crossing;
	logic [2:0]  profile_sel, prof7_mode;
	logic [1:0]  playback_dest;
	logic [15:0] prof7_step_rate;
	logic [9:0]  prof7_end_addr, prof7_start_addr;
	logic [31:0] mem_word;
	logic [63:0] rdat, pw;
	logic [3:0]  act, prev;
	int          n_fail, comparisons, n_oe, n_valid, k, i;
	// {write value, {enable, destination, keying pin enable}}
	scrb_row_t   rows [7] = '{'{32'h8000_0000, 4'h8}, '{32'h2000_0000, 4'h2},
		'{32'h4000_0000, 4'h4}, '{32'h6080_0200, 4'h7}, '{32'h0080_0100, 4'h0},
		'{32'h0080_0300, 4'h0}, '{32'h1F20_0000, 4'h0}};
	logic [4:0]  holes [4] = '{5'h05, 5'h06, 5'h17, 5'h1F};

	assign act = {wave_mem_enable, playback_dest, keying_pin_enable};

	scrb_bank u_scrb_bank (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.io_update(io_update), .profile_sel(profile_sel),
		.amplitude_keying(amplitude_keying),
		.amplitude_keying_gated(amplitude_keying_gated),
		.wave_mem_enable(wave_mem_enable), .playback_dest(playback_dest),
		.keying_pin_enable(keying_pin_enable), .prof7_step_rate(prof7_step_rate),
		.prof7_end_addr(prof7_end_addr), .prof7_start_addr(prof7_start_addr),
		.prof7_no_dwell_high(prof7_no_dwell_high),
		.prof7_zero_crossing(prof7_zero_crossing), .prof7_mode(prof7_mode),
		.mem_word(mem_word), .mem_word_valid(mem_word_valid));

	scrb_host u_scrb_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe));

	// ---------------------------------------------------------------
	// clock, monitors, helpers
	// ---------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(negedge ref_clk) begin
		if (sdio_oe === 1'b1)
			n_oe++;
		if (mem_word_valid === 1'b1)
			n_valid++;
	end

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// even: update strobe, odd: profile change
	task automatic upd(input int j);
		@(negedge ref_clk);
		if (j % 2 == 0)
			io_update = 1'b1;
		else
			profile_sel = profile_sel + 3'h1;
		@(negedge ref_clk) io_update = 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#500_000;
		n_fail++;
		give_verdict();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		io_update = 1'b0;
		profile_sel = 3'h0;
		amplitude_keying = 1'b1;
		prev = 4'h0;
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		chk("reset_ctrl", {act, amplitude_keying_gated}, 0);
		chk("reset_prof", {prof7_step_rate, prof7_end_addr, prof7_start_addr}, 0);
		for (i = 0; i < 7; i++) begin
			u_scrb_host.frame(1'b0, `SCRB_ADDR_CTRL_FIRST, 32, {32'h0, rows[i].wv}, rdat);
			chk("held", act, prev);
			u_scrb_host.frame(1'b1, `SCRB_ADDR_CTRL_FIRST, 32, 64'h0, rdat);
			chk("ctrl_read", rdat[31:0], rows[i].wv & `SCRB_CF_MASK);
			upd(i);
			chk("active", act, rows[i].ex);
			chk("gated", amplitude_keying_gated, rows[i].ex[0]);
			// pin low must show low whatever the enable
			amplitude_keying = 1'b0;
			repeat (2) @(negedge ref_clk);
			chk("gated_low", amplitude_keying_gated, 0);
			amplitude_keying = 1'b1;
			repeat (2) @(negedge ref_clk);
			prev = rows[i].ex;
		end
		// profile seven fields
		pw = 64'h0012_3456_789A_BCDE;
		u_scrb_host.frame(1'b0, `SCRB_ADDR_PROF_SEVEN, 64, pw, rdat);
		chk("p7_held", prof7_step_rate, 0);
		upd(1);
		chk("step", prof7_step_rate, pw[55:40]);
		chk("end", prof7_end_addr, pw[39:30]);
		chk("start", prof7_start_addr, pw[23:14]);
		chk("low", {prof7_no_dwell_high, prof7_zero_crossing, prof7_mode},
			{pw[5], pw[3], pw[2:0]});
		u_scrb_host.frame(1'b1, `SCRB_ADDR_PROF_SEVEN, 64, 64'h0, rdat);
		chk("p7_read", rdat, pw & `SCRB_PR_MASK);
		// aborted frame is dropped
		u_scrb_host.frame(1'b0, `SCRB_ADDR_CTRL_FIRST, 32, 64'hFFFF_FFFF, rdat, 28);
		upd(0);
		chk("cut", act, 0);
		// memory word gated by enable, not staged
		u_scrb_host.frame(1'b0, `SCRB_ADDR_MEM_WORD, 32, 64'hA5A5_5A5A, rdat);
		chk("mem_off", n_valid, 0);
		u_scrb_host.frame(1'b0, `SCRB_ADDR_CTRL_FIRST, 32, 64'h8000_0000, rdat);
		upd(0);
		u_scrb_host.frame(1'b0, `SCRB_ADDR_MEM_WORD, 32, 64'hA5A5_5A5A, rdat);
		chk("mem_valid", n_valid, 1);
		chk("mem_word", mem_word, 32'hA5A5_5A5A);
		// unimplemented and out-of-range addresses never answer
		k = n_oe;
		foreach (holes[j]) begin
			u_scrb_host.frame(1'b1, holes[j], 32, 64'h0, rdat);
			chk("hole_oe", n_oe, k);
		end
		u_scrb_host.frame(1'b1, `SCRB_ADDR_LAST, 32, 64'h0, rdat);
		chk("top_oe", n_oe > k, 1);
		chk("top_read", rdat[31:0], 32'hA5A5_5A5A);
		// second reset mid-run
		@(negedge ref_clk) rst_n = 1'b0;
		@(negedge ref_clk) rst_n = 1'b1;
		chk("reset2", {act, mem_word, prof7_step_rate}, 0);
		give_verdict();
	end
endmodule

`default_nettype wire
